//--- verilog/arp_pkg.sv
// Constants for the answer-to-reset sender and RF power command block
package arp_pkg;
   // Clock and link timing
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned ATR_RATE_BPS = 9600;
   localparam int unsigned ATR_BIT_CYC = CLK_HZ / ATR_RATE_BPS;
   localparam int unsigned BAUD_W = 16;
   localparam int unsigned UART_BITS = 11;
   // Answer-to-reset characters
   localparam logic [7:0] ATR_TS = 8'h3B;
   localparam logic [7:0] ATR_T0 = 8'hF3;
   localparam logic [7:0] ATR_TA1 = 8'h71;
   localparam logic [7:0] ATR_TB1 = 8'h00;
   localparam logic [7:0] ATR_TC1 = 8'hFF;
   localparam logic [7:0] ATR_TD1 = 8'h91;
   localparam logic [7:0] ATR_TA2 = 8'h81;
   localparam logic [7:0] ATR_TD2 = 8'h71;
   localparam logic [7:0] ATR_TA3 = 8'hFF;
   localparam logic [7:0] ATR_TB3 = 8'h01;
   localparam logic [7:0] ATR_TC3 = 8'h00;
   localparam logic [7:0] ATR_NODE = 8'h11;
   localparam logic [3:0] ATR_LAST_IDX = 4'hE;
   localparam logic [3:0] ATR_HIST_CNT = 4'h3;
   // Frame fields
   localparam logic [7:0] FRM_NODE = 8'h11;
   localparam logic [7:0] PWR_REQ_PCB = 8'hC5;
   localparam logic [7:0] PWR_REQ_LEN = 8'h01;
   localparam logic [2:0] REQ_LAST_IDX = 3'h5;
   localparam logic [7:0] PWR_ACK_PCB = 8'hE5;
   localparam logic [7:0] PWR_ACK_LEN = 8'h00;
   localparam logic [7:0] PWR_ACK_CRC1 = 8'hA4;
   localparam logic [7:0] PWR_ACK_CRC2 = 8'h8E;
   localparam logic [2:0] ACK_LAST_IDX = 3'h4;
   // Power option codes and their check bytes
   localparam logic [7:0] OPT_ON = 8'h00;
   localparam logic [7:0] OPT_OFF = 8'h01;
   localparam logic [7:0] OPT_DOWN = 8'h02;
   localparam logic [7:0] OPT_UP = 8'h03;
   localparam logic [15:0] CRC_ON = 16'h3B09;
   localparam logic [15:0] CRC_OFF = 16'hB218;
   localparam logic [15:0] CRC_DOWN = 16'h292A;
   localparam logic [15:0] CRC_UP = 16'hA03B;
   // Field power level
   localparam int unsigned PWR_W = 3;
   localparam logic [2:0] PWR_MIN = 3'h0;
   localparam logic [2:0] PWR_MAX = 3'h7;
   localparam logic [2:0] PWR_RST = 3'h4;
   localparam logic CARRIER_RST = 1'b1;
   typedef enum logic [1:0] {TX_ATR, TX_IDLE, TX_ACK} arp_tx_state_t;
endpackage

//--- verilog/arp_core.sv
// Answer-to-reset sender and RF power request interpreter
// Notes on behaviour
// - Initial character 3B, direct convention, LSB first
// - Format high nibble flags TA1-TD1, low counts history
// - TDi low nibble is protocol type
// - TDi high nibble flags next-level bytes
// - No TDi means no next-level bytes
// - At most fifteen historical characters
// - Check character XORs format through last byte
// - Send TS, T0, interface, history, check
// - Format character is F3
// - TA1 71, TB1 00, TC1 FF
// - TD1 91, TA2 81, TD2 71
// - TA3 FF, field size 255
// - TB3 01 and TC3 00 as printed
// - History: version MSB, version LSB, node 11
// - Terminal sends requests, reader sends responses
// - Options on, off, lower, raise; others forbidden
// - ATR at 9.6 kbit/s, then programmed rate
// - Two-byte CRC epilogue checked and sent
// - Acknowledge 11 E5 00 A4 8E
`timescale 1ns/1ps
module arp_core
   import arp_pkg::*;
#(
   parameter int unsigned ATR_BIT_CYCLES = ATR_BIT_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [7:0] fw_ver_msb_i,
   input wire logic [7:0] fw_ver_lsb_i,
   input wire logic [BAUD_W-1:0] baud_div_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_valid_i,
   output logic tx_serial_o,
   output logic tx_busy_o,
   output logic atr_done_o,
   output logic carrier_on_o,
   output logic [PWR_W-1:0] power_level_o,
   output logic req_exec_o,
   output logic req_drop_o
);

   // Fixed ATR byte by position; version bytes and check come from live values
   function automatic logic [7:0] atr_byte(input logic [3:0] idx,
                                           input logic [15:0] ver,
                                           input logic [7:0] tck);
      logic [7:0] b;
      b = 8'h00;
      case (idx)
         4'h0: b = ATR_TS;
         4'h1: b = ATR_T0;
         4'h2: b = ATR_TA1;
         4'h3: b = ATR_TB1;
         4'h4: b = ATR_TC1;
         4'h5: b = ATR_TD1;
         4'h6: b = ATR_TA2;
         4'h7: b = ATR_TD2;
         4'h8: b = ATR_TA3;
         4'h9: b = ATR_TB3;
         4'hA: b = ATR_TC3;
         4'hB: b = ver[15:8];
         4'hC: b = ver[7:0];
         4'hD: b = ATR_NODE;
         4'hE: b = tck;
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   // Acknowledge byte by position
   function automatic logic [7:0] ack_byte(input logic [2:0] idx);
      logic [7:0] b;
      b = 8'h00;
      case (idx)
         3'h0: b = FRM_NODE;
         3'h1: b = PWR_ACK_PCB;
         3'h2: b = PWR_ACK_LEN;
         3'h3: b = PWR_ACK_CRC1;
         3'h4: b = PWR_ACK_CRC2;
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   // Expected check bytes per option; valid low when option forbidden
   function automatic logic [16:0] opt_crc(input logic [7:0] opt);
      logic [16:0] r;
      r = 17'h0_0000;
      case (opt)
         OPT_ON: r = {1'b1, CRC_ON};
         OPT_OFF: r = {1'b1, CRC_OFF};
         OPT_DOWN: r = {1'b1, CRC_DOWN};
         OPT_UP: r = {1'b1, CRC_UP};
         default: r = 17'h0_0000;
      endcase
      return r;
   endfunction

   // Firmware version straps through two flip-flops
   logic [15:0] ver_meta_ff;
   logic [15:0] ver_ff;
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ver_meta_ff <= 16'h0000;
         ver_ff <= 16'h0000;
      end else begin
         ver_meta_ff <= {fw_ver_msb_i, fw_ver_lsb_i};
         ver_ff <= ver_meta_ff;
      end
   end

   // Serial shifter
   logic [UART_BITS-1:0] shift_ff;
   logic [3:0] bit_cnt_ff;
   logic [BAUD_W-1:0] baud_cnt_ff;
   logic shifting_ff;
   logic load;
   logic [7:0] load_byte;
   logic bit_end;
   logic byte_end;
   logic [BAUD_W-1:0] bit_len;

   // ATR always at the fixed rate, programmed rate afterwards
   always_comb begin
      bit_len = baud_div_i;
      if (!atr_done_o) begin
         bit_len = ATR_BIT_CYCLES[BAUD_W-1:0];
      end
   end

   assign bit_end = shifting_ff && (baud_cnt_ff == bit_len - 16'h0001);
   assign byte_end = bit_end && (bit_cnt_ff == 4'(UART_BITS - 1));

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         baud_cnt_ff <= 16'h0000;
      end else if (load || bit_end) begin
         baud_cnt_ff <= 16'h0000;
      end else if (shifting_ff) begin
         baud_cnt_ff <= baud_cnt_ff + 16'h0001;
      end
   end

   // Start low, data LSB first, even parity, stop high
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         shift_ff <= {UART_BITS{1'b1}};
         bit_cnt_ff <= 4'h0;
         shifting_ff <= 1'b0;
      end else if (load) begin
         shift_ff <= {1'b1, ^load_byte, load_byte, 1'b0};
         bit_cnt_ff <= 4'h0;
         shifting_ff <= 1'b1;
      end else if (byte_end) begin
         shift_ff <= {UART_BITS{1'b1}};
         shifting_ff <= 1'b0;
      end else if (bit_end) begin
         shift_ff <= {1'b1, shift_ff[UART_BITS-1:1]};
         bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         tx_serial_o <= 1'b1;
      end else begin
         tx_serial_o <= shift_ff[0];
      end
   end

   // Transmit sequencer
   arp_tx_state_t state_ff;
   arp_tx_state_t nxt_state;
   logic [3:0] idx_ff;
   logic [7:0] tck_ff;
   logic ack_pend_ff;
   logic ack_start;
   logic req_ok;

   assign load = !shifting_ff && (state_ff != TX_IDLE);
   assign ack_start = (state_ff == TX_IDLE) && ack_pend_ff && atr_done_o;

   always_comb begin
      load_byte = 8'h00;
      case (state_ff)
         TX_ATR: load_byte = atr_byte(idx_ff, ver_ff, tck_ff);
         TX_ACK: load_byte = ack_byte(idx_ff[2:0]);
         default: load_byte = 8'h00;
      endcase
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         TX_ATR: begin
            if (load && idx_ff == ATR_LAST_IDX) begin
               nxt_state = TX_IDLE;
            end
         end
         TX_IDLE: begin
            if (ack_start) begin
               nxt_state = TX_ACK;
            end
         end
         TX_ACK: begin
            if (load && idx_ff[2:0] == ACK_LAST_IDX) begin
               nxt_state = TX_IDLE;
            end
         end
         default: nxt_state = TX_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state_ff <= TX_ATR;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         idx_ff <= 4'h0;
      end else if (load && nxt_state == TX_IDLE) begin
         idx_ff <= 4'h0;
      end else if (load) begin
         idx_ff <= idx_ff + 4'h1;
      end
   end

   // Running XOR from the format character onward
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         tck_ff <= 8'h00;
      end else if (load && state_ff == TX_ATR && idx_ff != 4'h0) begin
         tck_ff <= tck_ff ^ load_byte;
      end
   end

   // Rate switches once the last ATR character has left the line
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         atr_done_o <= 1'b0;
      end else if (state_ff == TX_IDLE && !shifting_ff) begin
         atr_done_o <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         tx_busy_o <= 1'b1;
      end else begin
         tx_busy_o <= shifting_ff || (nxt_state != TX_IDLE) || ack_pend_ff;
      end
   end

   // A request in the cycle the queued acknowledge starts keeps the flag set; earlier ones share one acknowledge
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ack_pend_ff <= 1'b0;
      end else if (req_ok) begin
         ack_pend_ff <= 1'b1;
      end else if (ack_start) begin
         ack_pend_ff <= 1'b0;
      end
   end

   // Request parser
   logic [2:0] rx_idx_ff;
   logic [7:0] opt_ff;
   logic [7:0] crc1_ff;
   logic hdr_bad;
   logic frame_end;
   logic [16:0] exp_crc;

   always_comb begin
      hdr_bad = 1'b0;
      case (rx_idx_ff)
         3'h0: hdr_bad = (rx_data_i != FRM_NODE);
         3'h1: hdr_bad = (rx_data_i != PWR_REQ_PCB);
         3'h2: hdr_bad = (rx_data_i != PWR_REQ_LEN);
         default: hdr_bad = 1'b0;
      endcase
   end

   assign frame_end = rx_valid_i && (rx_idx_ff == REQ_LAST_IDX);
   assign exp_crc = opt_crc(opt_ff);
   assign req_ok = frame_end && exp_crc[16]
                   && (exp_crc[15:0] == {crc1_ff, rx_data_i});

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         rx_idx_ff <= 3'h0;
      end else if (rx_valid_i && (hdr_bad || frame_end)) begin
         rx_idx_ff <= 3'h0;
      end else if (rx_valid_i) begin
         rx_idx_ff <= rx_idx_ff + 3'h1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         opt_ff <= 8'h00;
         crc1_ff <= 8'h00;
      end else if (rx_valid_i && rx_idx_ff == 3'h3) begin
         opt_ff <= rx_data_i;
      end else if (rx_valid_i && rx_idx_ff == 3'h4) begin
         crc1_ff <= rx_data_i;
      end
   end

   // Carrier state, touched only by a clean request
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         carrier_on_o <= CARRIER_RST;
      end else if (req_ok && opt_ff == OPT_ON) begin
         carrier_on_o <= 1'b1;
      end else if (req_ok && opt_ff == OPT_OFF) begin
         carrier_on_o <= 1'b0;
      end
   end

   // Field power steps by one and saturates
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         power_level_o <= PWR_RST;
      end else if (req_ok && opt_ff == OPT_DOWN && power_level_o != PWR_MIN) begin
         power_level_o <= power_level_o - 3'h1;
      end else if (req_ok && opt_ff == OPT_UP && power_level_o != PWR_MAX) begin
         power_level_o <= power_level_o + 3'h1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         req_exec_o <= 1'b0;
         req_drop_o <= 1'b0;
      end else begin
         req_exec_o <= req_ok;
         req_drop_o <= frame_end && !req_ok;
      end
   end

endmodule

//--- verif/arp_core_sva.sv
// Port checker for the ATR sender and RF power interpreter
`timescale 1ns/1ps
module arp_core_sva
   import arp_pkg::*;
#(
   parameter int unsigned ATR_BIT_CYCLES = ATR_BIT_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [7:0] fw_ver_msb_i,
   input wire logic [7:0] fw_ver_lsb_i,
   input wire logic [BAUD_W-1:0] baud_div_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_valid_i,
   input wire logic tx_serial_o,
   input wire logic tx_busy_o,
   input wire logic atr_done_o,
   input wire logic carrier_on_o,
   input wire logic [PWR_W-1:0] power_level_o,
   input wire logic req_exec_o,
   input wire logic req_drop_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_exec_pulse;
      req_exec_o ##1 !req_exec_o;
   endsequence
   sequence s_drop_pulse;
      req_drop_o ##1 !req_drop_o;
   endsequence
   property p_exec_pulse;
      req_exec_o |-> s_exec_pulse;
   endproperty
   property p_drop_pulse;
      req_drop_o |-> s_drop_pulse;
   endproperty
   property p_excl;
      !(req_exec_o && req_drop_o);
   endproperty
   property p_done_sticky;
      atr_done_o |=> atr_done_o;
   endproperty
   property p_idle_high;
      !tx_busy_o |-> tx_serial_o;
   endproperty
   property p_change_cause;
      $changed(carrier_on_o) || $changed(power_level_o) |-> req_exec_o;
   endproperty
   property p_power_step;
      $changed(power_level_o) |-> 3'(power_level_o - $past(power_level_o)) inside {3'h1, 3'h7};
   endproperty
   property p_drop_hold;
      req_drop_o |-> $stable(carrier_on_o) && $stable(power_level_o);
   endproperty
   property p_exec_cause;
      req_exec_o |-> $past(rx_valid_i) || $past(rx_valid_i, 2);
   endproperty
   a_exec_pulse: assert property (p_exec_pulse) else $error("exec pulse too long");
   a_drop_pulse: assert property (p_drop_pulse) else $error("drop pulse too long");
   a_excl: assert property (p_excl) else $error("exec and drop together");
   a_done_sticky: assert property (p_done_sticky) else $error("atr done fell");
   a_idle_high: assert property (p_idle_high) else $error("idle line low");
   a_change_cause: assert property (p_change_cause) else $error("state change unasked");
   a_power_step: assert property (p_power_step) else $error("power step not one");
   a_drop_hold: assert property (p_drop_hold) else $error("drop changed state");
   a_exec_cause: assert property (p_exec_cause) else $error("exec without byte");
endmodule

bind arp_core arp_core_sva #(.ATR_BIT_CYCLES(ATR_BIT_CYCLES)) u_sva (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .fw_ver_msb_i(fw_ver_msb_i),
   .fw_ver_lsb_i(fw_ver_lsb_i), .baud_div_i(baud_div_i), .rx_data_i(rx_data_i),
   .rx_valid_i(rx_valid_i), .tx_serial_o(tx_serial_o), .tx_busy_o(tx_busy_o),
   .atr_done_o(atr_done_o), .carrier_on_o(carrier_on_o), .power_level_o(power_level_o),
   .req_exec_o(req_exec_o), .req_drop_o(req_drop_o));

//--- verif/arp_host.sv
// Host terminal model: serial receiver and request sender
`timescale 1ns/1ps
module arp_host #(
   parameter int unsigned ATR_BITS = 8
) (
   input wire logic clk_i,
   input wire logic line_i,
   input wire logic atr_done_i,
   input wire logic [15:0] baud_i,
   output logic [7:0] rx_data_o,
   output logic rx_valid_o
);
   logic [7:0] rx_q [$];
   logic perr;
   initial begin
      int bl;
      logic [7:0] b;
      logic par;
      rx_valid_o = 1'b0;
      rx_data_o = 8'h00;
      perr = 1'b0;
      forever begin
         @(negedge clk_i);
         if (!line_i) begin
            bl = atr_done_i ? int'(baud_i) : ATR_BITS;
            repeat (bl / 2) @(negedge clk_i);
            for (int i = 0; i < 8; i++) begin
               repeat (bl) @(negedge clk_i);
               b[i] = line_i;
            end
            repeat (bl) @(negedge clk_i);
            par = line_i;
            repeat (bl) @(negedge clk_i);
            perr = perr | (^b != par) | !line_i;
            rx_q.push_back(b);
         end
      end
   end
   task automatic send(input logic [7:0] opt, input logic [15:0] crc);
      logic [7:0] f [6];
      f = '{8'h11, 8'hC5, 8'h01, opt, crc[15:8], crc[7:0]};
      foreach (f[i]) begin
         @(negedge clk_i);
         rx_data_o = f[i];
         rx_valid_o = 1'b1;
      end
      @(negedge clk_i);
      rx_valid_o = 1'b0;
      rx_data_o = ~f[5];
   endtask
endmodule

//--- verif/tb.sv
// Testbench for the ATR sender and RF power interpreter
`timescale 1ns/1ps
module tb;
   import arp_pkg::*;
   localparam logic [7:0] VER_HI = 8'hA5;
   localparam logic [7:0] VER_LO = 8'h3C;
   logic clk_sys_i, rst_n_i, tx_serial_o, tx_busy_o, atr_done_o, carrier_on_o;
   logic req_exec_o, req_drop_o, rx_valid_i;
   logic [7:0] rx_data_i;
   logic [BAUD_W-1:0] baud_div_i;
   logic [PWR_W-1:0] power_level_o;
   int fails, check_count;
   arp_core #(.ATR_BIT_CYCLES(8)) uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .fw_ver_msb_i(VER_HI), .fw_ver_lsb_i(VER_LO), .baud_div_i(baud_div_i),
      .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .tx_serial_o(tx_serial_o),
      .tx_busy_o(tx_busy_o), .atr_done_o(atr_done_o), .carrier_on_o(carrier_on_o),
      .power_level_o(power_level_o), .req_exec_o(req_exec_o), .req_drop_o(req_drop_o));
   arp_host #(.ATR_BITS(8)) u_host (.clk_i(clk_sys_i), .line_i(tx_serial_o),
      .atr_done_i(atr_done_o), .baud_i(baud_div_i), .rx_data_o(rx_data_i),
      .rx_valid_o(rx_valid_i));
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(string nm, logic e, logic g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic wait_bytes(int n, int lim);
      for (int i = 0; i < lim && u_host.rx_q.size() < n; i++) @(negedge clk_sys_i);
      if (u_host.rx_q.size() < n) begin
         fails++;
         print_verdict();
      end
   endtask
   task automatic t_atr();
      logic [7:0] e [15];
      e = '{8'h3B, 8'hF3, 8'h71, 8'h00, 8'hFF, 8'h91, 8'h81, 8'h71, 8'hFF, 8'h01, 8'h00,
            VER_HI, VER_LO, 8'h11, 8'h00};
      for (int i = 1; i < 14; i++) e[14] = e[14] ^ e[i];
      wait_bytes(15, 3000);
      foreach (e[i]) chk_byte("atr byte", e[i], u_host.rx_q.pop_front());
      repeat (20) @(negedge clk_sys_i);
      chk_bit("atr done", 1'b1, atr_done_o);
      chk_bit("parity error", 1'b0, u_host.perr);
   endtask
   task automatic t_req(logic [7:0] opt, logic [15:0] crc, logic ex, logic car, logic [2:0] lv);
      logic se, sd;
      logic [7:0] ack [5];
      ack = '{8'h11, 8'hE5, 8'h00, 8'hA4, 8'h8E};
      se = 1'b0;
      sd = 1'b0;
      u_host.send(opt, crc);
      repeat (4) begin
         se = se | req_exec_o;
         sd = sd | req_drop_o;
         @(negedge clk_sys_i);
      end
      chk_bit("exec", ex, se);
      chk_bit("drop", !ex, sd);
      chk_bit("carrier", car, carrier_on_o);
      chk_byte("power", {5'h00, lv}, {5'h00, power_level_o});
      if (ex) begin
         wait_bytes(5, 600);
         foreach (ack[i]) chk_byte("ack byte", ack[i], u_host.rx_q.pop_front());
      end else begin
         repeat (300) @(negedge clk_sys_i);
         chk_byte("ack count", 8'h00, 8'(u_host.rx_q.size()));
      end
   endtask
   task automatic t_rst_req();
      logic [7:0] ack [5];
      ack = '{8'h11, 8'hE5, 8'h00, 8'hA4, 8'h8E};
      rst_n_i = 1'b0;
      repeat (20) @(negedge clk_sys_i);
      chk_bit("rst carrier", 1'b1, carrier_on_o);
      chk_byte("rst power", 8'h04, {5'h00, power_level_o});
      chk_bit("rst busy", 1'b1, tx_busy_o);
      chk_bit("rst done", 1'b0, atr_done_o);
      chk_bit("rst line", 1'b1, tx_serial_o);
      rst_n_i = 1'b1;
      u_host.send(8'h03, 16'hA03B);
      chk_byte("early power", 8'h05, {5'h00, power_level_o});
      chk_bit("early busy", 1'b1, tx_busy_o);
      t_atr();
      wait_bytes(5, 600);
      foreach (ack[i]) chk_byte("late ack byte", ack[i], u_host.rx_q.pop_front());
   endtask
   initial begin
      fails = 0;
      check_count = 0;
      rst_n_i = 1'b0;
      baud_div_i = 16'h0004;
      repeat (20) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      t_atr();
      chk_bit("idle busy", 1'b0, tx_busy_o);
      t_req(8'h01, 16'hB218, 1'b1, 1'b0, 3'h4);
      t_req(8'h00, 16'h3B09, 1'b1, 1'b1, 3'h4);
      t_req(8'h02, 16'h292A, 1'b1, 1'b1, 3'h3);
      t_req(8'h03, 16'hA03B, 1'b1, 1'b1, 3'h4);
      t_req(8'h01, 16'hB219, 1'b0, 1'b1, 3'h4);
      t_req(8'h04, 16'h3B09, 1'b0, 1'b1, 3'h4);
      for (int i = 0; i < 4; i++) t_req(8'h03, 16'hA03B, 1'b1, 1'b1, 3'(i < 3 ? 5 + i : 7));
      for (int i = 0; i < 8; i++) t_req(8'h02, 16'h292A, 1'b1, 1'b1, 3'(i < 7 ? 6 - i : 0));
      t_rst_req();
      print_verdict();
   end
endmodule
